// ===== amp_fault_defines.svh
`ifndef AMP_FAULT_DEFINES_SVH
`define AMP_FAULT_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_SUPPLY_CLOCK_FAULT 8'h71
`define OFS_THERMAL_OC_FAULT 8'h72
`define OFS_WARNING 8'h73
`define OFS_PIN_MASK1 8'h74
`define OFS_PIN_MASK2 8'h75
`define OFS_FAULT_CLEAR 8'h78

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_UNDERVOLTAGE 0
`define BIT_OVERVOLTAGE 1
`define BIT_CLOCK_FAULT 2
`define BIT_THERMAL_SHUTDOWN 0
`define BIT_LEFT_CURRENT_FAULT 1
`define BIT_RIGHT_CURRENT_FAULT 2
`define BIT_THERMAL_WARN_ONE 0
`define BIT_THERMAL_WARN_TWO 1
`define BIT_THERMAL_WARN_THREE 2
`define BIT_THERMAL_WARN_FOUR 3
`define BIT_RIGHT_CURRENT_WARN 4
`define BIT_LEFT_CURRENT_WARN 5
`define BIT_MASK_CURRENT_FAULT 0
`define BIT_MASK_SUPPLY_UV 2
`define BIT_MASK_CLOCK_FAULT 4
`define BIT_MASK_THERMAL_SHUTDOWN 7
`define BIT_MASK_CURRENT_WARN 1
`define BIT_MASK_THERMAL_WARN 2
`define BIT_ANALOG_FAULT_CLEAR 7

// ----------------------------------------------------------------
// reset values and thresholds (degrees C)
// ----------------------------------------------------------------
`define RESET_STATUS 8'h00
`define RESET_PIN_MASK1 8'h00
`define RESET_PIN_MASK2 8'h00
`define THERMAL_LEVEL_ONE_C 112
`define THERMAL_LEVEL_TWO_C 122
`define THERMAL_LEVEL_THREE_C 134
`define THERMAL_LEVEL_FOUR_C 146

`endif

// ===== amp_fault_pkg.sv
package amp_fault_pkg;

   // live detector conditions, one bit each, active high
   typedef struct packed {
      logic clock_error;
      logic supply_overvoltage;
      logic supply_undervoltage;
      logic thermal_shutdown;
      logic left_current_fault;
      logic right_current_fault;
      logic left_current_warning;
      logic right_current_warning;
   } detector_s;

   // host register port request
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_s;

endpackage

// ===== input_sync.sv
`timescale 1ns/10ps
`default_nettype none

module input_sync #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,             // system clock
   input wire logic reset_n,          // synchronous reset, active low
   input wire logic [WIDTH-1:0] d,    // asynchronous levels
   output logic [WIDTH-1:0] q         // filtered synchronous levels
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // elaboration check: an empty chain has nothing to filter
   if (WIDTH < 1) begin : g_width_check
      $error("input_sync: WIDTH must be at least 1");
   end

   // ----------------------------------------------------------------
   // three-stage chain
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= d;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // ----------------------------------------------------------------
   // accept a change only once stages two and three agree
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               q[i] <= stage3[i];
            end
         end
      end
   end

endmodule // input_sync

`default_nettype wire

// ===== sticky_flag.sv
`timescale 1ns/10ps
`default_nettype none

module sticky_flag #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,             // system clock
   input wire logic reset_n,          // synchronous reset, active low
   input wire logic [WIDTH-1:0] set,  // event levels
   input wire logic clear,            // one-cycle clear pulse
   output logic [WIDTH-1:0] flag      // latched flags
);

   // elaboration check: at least one flag is needed
   if (WIDTH < 1) begin : g_width_check
      $error("sticky_flag: WIDTH must be at least 1");
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         flag <= '0;
      end else begin
         flag <= (clear ? '0 : flag) | set;
      end
   end

endmodule // sticky_flag

`default_nettype wire

// ===== amp_fault_warning_status.sv
// Functional notes
// - clock error sets fault bit 2
// - supply, clock, thermal faults tri-state outputs
// - such faults reported on fault pin
// - clock fault clears, outputs resume automatically
// - flags stay set until clear written
// - overvoltage sets fault bit 1
// - overvoltage removed, outputs resume automatically
// - undervoltage sets fault bit 0
// - thermal shutdown sets bit 0, tri-states, reports
// - right current fault bit 2, left bit 1
// - second fault register bits 7-3 read zero
// - left current warning bit 5, right 4
// - warning bits 0,1 at 112C, 122C
// - warning bits 2,3 at 134C, 146C
// - writing clear bit 7 clears latched faults
// - clock fault mask hides it from pin
`timescale 1ns/10ps
`default_nettype none
`include "amp_fault_defines.svh"

module amp_fault_warning_status #(
   parameter int TEMP_WIDTH = 8
) (
   input wire logic mclk,                         // system clock, 50 MHz
   input wire logic reset_n,                      // synchronous reset, active low
   input wire amp_fault_pkg::detector_s detect,   // asynchronous detector levels
   input wire logic [TEMP_WIDTH-1:0] die_temp,    // die temperature in C, mclk domain
   input wire amp_fault_pkg::reg_req_s req,       // host register request
   output logic [7:0] rdata,                      // read data, valid cycle after rd
   output logic power_stage_hiz,                  // both class-D outputs high impedance
   output logic fault_n                           // fault pin level, active low
);
   import amp_fault_pkg::*;

   // elaboration check: the highest threshold needs eight bits
   if (TEMP_WIDTH < 8) begin : g_temp_width_check
      $error("amp_fault_warning_status: TEMP_WIDTH must be at least 8");
   end

   // ----------------------------------------------------------------
   // detector synchronisation
   // ----------------------------------------------------------------
   detector_s live;
   logic [7:0] live_bits;

   input_sync #(.WIDTH(8)) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .d(detect),
      .q(live_bits)
   );

   assign live = detector_s'(live_bits);

   // ----------------------------------------------------------------
   // thermal warning comparators
   // ----------------------------------------------------------------
   localparam logic [TEMP_WIDTH-1:0] TEMP_ONE = TEMP_WIDTH'(`THERMAL_LEVEL_ONE_C);
   localparam logic [TEMP_WIDTH-1:0] TEMP_TWO = TEMP_WIDTH'(`THERMAL_LEVEL_TWO_C);
   localparam logic [TEMP_WIDTH-1:0] TEMP_THREE = TEMP_WIDTH'(`THERMAL_LEVEL_THREE_C);
   localparam logic [TEMP_WIDTH-1:0] TEMP_FOUR = TEMP_WIDTH'(`THERMAL_LEVEL_FOUR_C);

   logic [3:0] thermal_level;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         thermal_level <= 4'h0;
      end else begin
         thermal_level[`BIT_THERMAL_WARN_ONE] <= die_temp >= TEMP_ONE;
         thermal_level[`BIT_THERMAL_WARN_TWO] <= die_temp >= TEMP_TWO;
         thermal_level[`BIT_THERMAL_WARN_THREE] <= die_temp >= TEMP_THREE;
         thermal_level[`BIT_THERMAL_WARN_FOUR] <= die_temp >= TEMP_FOUR;
      end
   end

   // ----------------------------------------------------------------
   // host writes: masks and clear strobe
   // ----------------------------------------------------------------
   logic [7:0] pin_mask1;
   logic [7:0] pin_mask2;
   logic analog_fault_clear;

   // status offsets fall through untouched: they hold no writable bits
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pin_mask1 <= `RESET_PIN_MASK1;
         pin_mask2 <= `RESET_PIN_MASK2;
      end else if (req.wr) begin
         unique case (req.addr)
            `OFS_PIN_MASK1: pin_mask1 <= req.wdata & 8'hf7;
            `OFS_PIN_MASK2: pin_mask2 <= req.wdata & 8'h07;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         analog_fault_clear <= 1'b0;
      end else begin
         analog_fault_clear <= req.wr && req.addr == `OFS_FAULT_CLEAR
            && req.wdata[`BIT_ANALOG_FAULT_CLEAR];
      end
   end

   // ----------------------------------------------------------------
   // latched status flags
   // ----------------------------------------------------------------
   logic [7:0] next_fault1_set;
   logic [7:0] next_fault2_set;
   logic [7:0] next_warn_set;
   logic [7:0] supply_clock_fault_status;
   logic [7:0] thermal_overcurrent_fault_status;
   logic [7:0] warning_status;

   always_comb begin
      next_fault1_set = 8'h00;
      next_fault1_set[`BIT_CLOCK_FAULT] = live.clock_error;
      next_fault1_set[`BIT_OVERVOLTAGE] = live.supply_overvoltage;
      next_fault1_set[`BIT_UNDERVOLTAGE] = live.supply_undervoltage;
      next_fault2_set = 8'h00;
      next_fault2_set[`BIT_THERMAL_SHUTDOWN] = live.thermal_shutdown;
      next_fault2_set[`BIT_RIGHT_CURRENT_FAULT] = live.right_current_fault;
      next_fault2_set[`BIT_LEFT_CURRENT_FAULT] = live.left_current_fault;
      next_warn_set = 8'h00;
      next_warn_set[3:0] = thermal_level;
      next_warn_set[`BIT_LEFT_CURRENT_WARN] = live.left_current_warning;
      next_warn_set[`BIT_RIGHT_CURRENT_WARN] = live.right_current_warning;
   end

   sticky_flag #(.WIDTH(24)) u_flags (
      .mclk(mclk),
      .reset_n(reset_n),
      .set({next_fault1_set, next_fault2_set, next_warn_set}),
      .clear(analog_fault_clear),
      .flag({supply_clock_fault_status, thermal_overcurrent_fault_status, warning_status})
   );

   // ----------------------------------------------------------------
   // power stage and fault pin
   // ----------------------------------------------------------------
   logic next_fault_report;

   // hiz follows the live condition so the stage recovers by itself
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         power_stage_hiz <= 1'b1;
      end else begin
         power_stage_hiz <= live.clock_error | live.supply_overvoltage
            | live.supply_undervoltage | live.thermal_shutdown;
      end
   end

   always_comb begin
      next_fault_report =
         (supply_clock_fault_status[`BIT_CLOCK_FAULT]
            & ~pin_mask1[`BIT_MASK_CLOCK_FAULT])
         | supply_clock_fault_status[`BIT_OVERVOLTAGE]
         | (supply_clock_fault_status[`BIT_UNDERVOLTAGE]
            & ~pin_mask1[`BIT_MASK_SUPPLY_UV])
         | (thermal_overcurrent_fault_status[`BIT_THERMAL_SHUTDOWN]
            & ~pin_mask1[`BIT_MASK_THERMAL_SHUTDOWN])
         | (|thermal_overcurrent_fault_status[2:1]
            & ~pin_mask2[`BIT_MASK_CURRENT_FAULT])
         | (|warning_status[5:4] & ~pin_mask2[`BIT_MASK_CURRENT_WARN])
         | (|warning_status[3:0] & ~pin_mask2[`BIT_MASK_THERMAL_WARN]);
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         fault_n <= 1'b1;
      end else begin
         fault_n <= ~next_fault_report;
      end
   end

   // ----------------------------------------------------------------
   // host reads
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            `OFS_SUPPLY_CLOCK_FAULT: rdata <= supply_clock_fault_status & 8'h07;
            `OFS_THERMAL_OC_FAULT: rdata <= thermal_overcurrent_fault_status & 8'h07;
            `OFS_WARNING: rdata <= warning_status & 8'h3f;
            `OFS_PIN_MASK1: rdata <= pin_mask1;
            `OFS_PIN_MASK2: rdata <= pin_mask2;
            default: rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_clock_fault_set: assert property (@(posedge mclk) disable iff (!reset_n)
      live.clock_error |=> supply_clock_fault_status[`BIT_CLOCK_FAULT])
      else $error("clock fault flag not set");

   a_overvolt_set: assert property (@(posedge mclk) disable iff (!reset_n)
      live.supply_overvoltage |=> supply_clock_fault_status[`BIT_OVERVOLTAGE])
      else $error("overvoltage flag not set");

   a_undervolt_set: assert property (@(posedge mclk) disable iff (!reset_n)
      live.supply_undervoltage |=> supply_clock_fault_status[`BIT_UNDERVOLTAGE])
      else $error("undervoltage flag not set");

   a_hiz_on_fault: assert property (@(posedge mclk) disable iff (!reset_n)
      (live.clock_error || live.thermal_shutdown) |=> power_stage_hiz)
      else $error("outputs not tri-stated on fault");

   // reset_n sampled in the antecedent: hiz still stands one edge after release
   a_hiz_recovers: assert property (@(posedge mclk) disable iff (!reset_n)
      reset_n && !live.clock_error && !live.supply_overvoltage && !live.supply_undervoltage
      && !live.thermal_shutdown |=> !power_stage_hiz)
      else $error("outputs did not resume");

   a_flag_holds: assert property (@(posedge mclk) disable iff (!reset_n)
      supply_clock_fault_status[`BIT_CLOCK_FAULT] && !analog_fault_clear
      |=> supply_clock_fault_status[`BIT_CLOCK_FAULT])
      else $error("latched flag dropped without clear");

   a_clear_works: assert property (@(posedge mclk) disable iff (!reset_n)
      req.wr && req.addr == `OFS_FAULT_CLEAR && req.wdata[7]
      ##1 (next_fault2_set == 8'h00) |=> thermal_overcurrent_fault_status == 8'h00)
      else $error("clear did not empty flags");

   a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
      thermal_overcurrent_fault_status[7:3] == 5'h00)
      else $error("reserved bits set");

   a_warn_level: assert property (@(posedge mclk) disable iff (!reset_n)
      die_temp >= TEMP_ONE |=> ##1 warning_status[`BIT_THERMAL_WARN_ONE])
      else $error("thermal warning one not set");

   a_clock_masked: assert property (@(posedge mclk) disable iff (!reset_n)
      pin_mask1[`BIT_MASK_CLOCK_FAULT] && supply_clock_fault_status == 8'h04
      && thermal_overcurrent_fault_status == 8'h00 && warning_status == 8'h00
      |=> fault_n)
      else $error("masked clock fault reached pin");

   a_pin_reports: assert property (@(posedge mclk) disable iff (!reset_n)
      supply_clock_fault_status[`BIT_OVERVOLTAGE] |=> !fault_n)
      else $error("fault pin not asserted");

   a_status_readonly: assert property (@(posedge mclk) disable iff (!reset_n)
      req.wr && req.addr == `OFS_WARNING && warning_status == 8'h00
      && next_warn_set == 8'h00 |=> warning_status == 8'h00)
      else $error("status changed by host write");

   a_supply_readonly: assert property (@(posedge mclk) disable iff (!reset_n)
      req.wr && req.addr == `OFS_SUPPLY_CLOCK_FAULT && supply_clock_fault_status == 8'h00
      && next_fault1_set == 8'h00 |=> supply_clock_fault_status == 8'h00)
      else $error("supply status changed by host write");

   a_hiz_on_supply: assert property (@(posedge mclk) disable iff (!reset_n)
      (live.supply_overvoltage || live.supply_undervoltage) |=> power_stage_hiz)
      else $error("outputs not tri-stated on supply fault");

   a_thermal_sd_set: assert property (@(posedge mclk) disable iff (!reset_n)
      live.thermal_shutdown |=> thermal_overcurrent_fault_status[`BIT_THERMAL_SHUTDOWN])
      else $error("thermal shutdown flag not set");

   a_left_fault_set: assert property (@(posedge mclk) disable iff (!reset_n)
      live.left_current_fault |=> thermal_overcurrent_fault_status[`BIT_LEFT_CURRENT_FAULT])
      else $error("left current fault flag not set");

   a_right_fault_set: assert property (@(posedge mclk) disable iff (!reset_n)
      live.right_current_fault |=> thermal_overcurrent_fault_status[`BIT_RIGHT_CURRENT_FAULT])
      else $error("right current fault flag not set");

   a_left_warn_set: assert property (@(posedge mclk) disable iff (!reset_n)
      live.left_current_warning |=> warning_status[`BIT_LEFT_CURRENT_WARN])
      else $error("left current warning not set");

   a_right_warn_set: assert property (@(posedge mclk) disable iff (!reset_n)
      live.right_current_warning |=> warning_status[`BIT_RIGHT_CURRENT_WARN])
      else $error("right current warning not set");

   a_warn_level_two: assert property (@(posedge mclk) disable iff (!reset_n)
      die_temp >= TEMP_TWO |=> ##1 warning_status[`BIT_THERMAL_WARN_TWO])
      else $error("thermal warning two not set");

   a_warn_level_three: assert property (@(posedge mclk) disable iff (!reset_n)
      die_temp >= TEMP_THREE |=> ##1 warning_status[`BIT_THERMAL_WARN_THREE])
      else $error("thermal warning three not set");

   a_warn_level_four: assert property (@(posedge mclk) disable iff (!reset_n)
      die_temp >= TEMP_FOUR |=> ##1 warning_status[`BIT_THERMAL_WARN_FOUR])
      else $error("thermal warning four not set");

   a_read_reserved: assert property (@(posedge mclk) disable iff (!reset_n)
      req.rd && req.addr == `OFS_THERMAL_OC_FAULT |=> rdata[7:3] == 5'h00)
      else $error("reserved bits read as one");

   a_clear_reads_zero: assert property (@(posedge mclk) disable iff (!reset_n)
      req.rd && req.addr == `OFS_FAULT_CLEAR |=> rdata == 8'h00)
      else $error("write-only clear register read nonzero");

   a_undervolt_report: assert property (@(posedge mclk) disable iff (!reset_n)
      supply_clock_fault_status[`BIT_UNDERVOLTAGE] && !pin_mask1[`BIT_MASK_SUPPLY_UV]
      |=> !fault_n)
      else $error("undervoltage not reported on pin");

   a_thermal_sd_report: assert property (@(posedge mclk) disable iff (!reset_n)
      thermal_overcurrent_fault_status[`BIT_THERMAL_SHUTDOWN]
      && !pin_mask1[`BIT_MASK_THERMAL_SHUTDOWN] |=> !fault_n)
      else $error("thermal shutdown not reported on pin");

   a_fault_pin_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
      supply_clock_fault_status == 8'h00 && thermal_overcurrent_fault_status == 8'h00
      && warning_status == 8'h00 |=> fault_n)
      else $error("fault pin asserted with no flag set");

endmodule // amp_fault_warning_status

`default_nettype wire

// ===== host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "amp_fault_defines.svh"

module host_model (
   input wire logic mclk,                    // system clock
   output var amp_fault_pkg::reg_req_s req,  // register request
   input wire logic [7:0] rdata              // read data
);
   import amp_fault_pkg::*;

   // ---------------------------------------------------------------
   // host register access
   // ---------------------------------------------------------------
   // idle edges before each request, raised to act as a slow host
   int unsigned gap = 0;

   initial req = '0;

   // one strobe per request; idle address and data are scrambled
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      repeat (gap) @(posedge mclk);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge mclk);
      req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      repeat (gap) @(posedge mclk);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge mclk);
      req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'h5a};
      #1;
      d = rdata;
   endtask

   task automatic clear_faults;
      write_reg(`OFS_FAULT_CLEAR, 8'h80);
   endtask
endmodule // host_model

`default_nettype wire

// ===== amp_fault_warning_status_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "amp_fault_defines.svh"

module amp_fault_warning_status_tb_top;
   import amp_fault_pkg::*;

   typedef struct packed {
      logic [7:0] det;
      logic [7:0] temp;
      logic [7:0] sc;
      logic [7:0] tc;
      logic [7:0] wn;
      logic hiz;
      logic fault_n;
   } row_s;

   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   detector_s detect = '0;
   logic [7:0] die_temp = 8'd25;
   reg_req_s req;
   logic [7:0] rdata;
   logic power_stage_hiz;
   logic fault_n;
   int num_errors = 0;
   int compares = 0;
   logic [7:0] v;
   row_s rows [13];

   always #10 mclk = ~mclk;

   amp_fault_warning_status #(.TEMP_WIDTH(8)) i_amp_fault_warning_status (
      .mclk(mclk), .reset_n(reset_n), .detect(detect), .die_temp(die_temp), .req(req),
      .rdata(rdata), .power_stage_hiz(power_stage_hiz), .fault_n(fault_n));

   host_model i_host_model (.mclk(mclk), .req(req), .rdata(rdata));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_host_model.read_reg(a, v);
      check(v, exp);
   endtask

   task automatic rd_all(input logic [7:0] sc, input logic [7:0] tc, input logic [7:0] wn);
      rd_chk(`OFS_SUPPLY_CLOCK_FAULT, sc);
      rd_chk(`OFS_THERMAL_OC_FAULT, tc);
      rd_chk(`OFS_WARNING, wn);
   endtask

   task automatic apply(input logic [7:0] d, input logic [7:0] t);
      @(posedge mclk);
      detect <= detector_s'(d);
      die_temp <= t;
   endtask

   // long enough for synchroniser, flag and pin stages
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic end_of_test;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      $display("watchdog expired at %0t", $time);
      end_of_test();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      rows[0] = '{8'h80, 8'd25, 8'h04, 8'h00, 8'h00, 1'b1, 1'b0};
      rows[1] = '{8'h40, 8'd25, 8'h02, 8'h00, 8'h00, 1'b1, 1'b0};
      rows[2] = '{8'h20, 8'd25, 8'h01, 8'h00, 8'h00, 1'b1, 1'b0};
      rows[3] = '{8'h10, 8'd25, 8'h00, 8'h01, 8'h00, 1'b1, 1'b0};
      rows[4] = '{8'h08, 8'd25, 8'h00, 8'h02, 8'h00, 1'b0, 1'b0};
      rows[5] = '{8'h04, 8'd25, 8'h00, 8'h04, 8'h00, 1'b0, 1'b0};
      rows[6] = '{8'h02, 8'd25, 8'h00, 8'h00, 8'h20, 1'b0, 1'b0};
      rows[7] = '{8'h01, 8'd25, 8'h00, 8'h00, 8'h10, 1'b0, 1'b0};
      rows[8] = '{8'h00, 8'd111, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1};
      rows[9] = '{8'h00, 8'd112, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0};
      rows[10] = '{8'h00, 8'd122, 8'h00, 8'h00, 8'h03, 1'b0, 1'b0};
      rows[11] = '{8'h00, 8'd134, 8'h00, 8'h00, 8'h07, 1'b0, 1'b0};
      rows[12] = '{8'h00, 8'd146, 8'h00, 8'h00, 8'h0f, 1'b0, 1'b0};
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      settle(8);
      check({7'h00, fault_n}, 8'h01);
      rd_all(8'h00, 8'h00, 8'h00);
      rd_chk(`OFS_FAULT_CLEAR, 8'h00);
      rd_chk(`OFS_PIN_MASK1, `RESET_PIN_MASK1);
      rd_chk(`OFS_PIN_MASK2, `RESET_PIN_MASK2);
      rd_chk(8'h7f, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 13; i++) begin
         apply(rows[i].det, rows[i].temp);
         settle(8);
         check({7'h00, power_stage_hiz}, {7'h00, rows[i].hiz});
         check({7'h00, fault_n}, {7'h00, rows[i].fault_n});
         rd_all(rows[i].sc, rows[i].tc, rows[i].wn);
         apply(8'h00, 8'd25);
         settle(8);
         check({7'h00, power_stage_hiz}, 8'h00);
         rd_all(rows[i].sc, rows[i].tc, rows[i].wn);
         i_host_model.clear_faults();
         settle(3);
         check({7'h00, fault_n}, 8'h01);
         rd_all(8'h00, 8'h00, 8'h00);
         $display("row test %0d done", i);
      end
      apply(8'h18, 8'd25);
      settle(8);
      i_host_model.write_reg(`OFS_SUPPLY_CLOCK_FAULT, 8'hff);
      i_host_model.write_reg(`OFS_THERMAL_OC_FAULT, 8'h00);
      i_host_model.write_reg(`OFS_WARNING, 8'hff);
      rd_all(8'h00, 8'h03, 8'h00);
      apply(8'h00, 8'd25);
      settle(8);
      i_host_model.clear_faults();
      $display("read-only test done");
      i_host_model.gap = 3;
      i_host_model.write_reg(`OFS_PIN_MASK1, 8'h10);
      apply(8'h80, 8'd25);
      settle(8);
      check({7'h00, power_stage_hiz}, 8'h01);
      check({7'h00, fault_n}, 8'h01);
      rd_chk(`OFS_SUPPLY_CLOCK_FAULT, 8'h04);
      i_host_model.write_reg(`OFS_PIN_MASK1, 8'h00);
      settle(3);
      check({7'h00, fault_n}, 8'h00);
      i_host_model.clear_faults();
      settle(3);
      rd_chk(`OFS_SUPPLY_CLOCK_FAULT, 8'h04);
      apply(8'h00, 8'd25);
      settle(8);
      i_host_model.clear_faults();
      settle(3);
      rd_chk(`OFS_SUPPLY_CLOCK_FAULT, 8'h00);
      check({7'h00, fault_n}, 8'h01);
      $display("mask test done");
      i_host_model.write_reg(`OFS_PIN_MASK1, 8'hff);
      i_host_model.write_reg(`OFS_PIN_MASK2, 8'hff);
      rd_chk(`OFS_PIN_MASK1, 8'hf7);
      rd_chk(`OFS_PIN_MASK2, 8'h07);
      apply(8'h3f, 8'd146);
      settle(8);
      check({7'h00, power_stage_hiz}, 8'h01);
      check({7'h00, fault_n}, 8'h01);
      rd_all(8'h01, 8'h07, 8'h3f);
      i_host_model.write_reg(`OFS_PIN_MASK2, 8'h00);
      settle(3);
      check({7'h00, fault_n}, 8'h00);
      $display("mask all test done");
      apply(8'h00, 8'd25);
      @(posedge mclk);
      reset_n <= 1'b0;
      settle(4);
      check({7'h00, fault_n}, 8'h01);
      @(posedge mclk);
      reset_n <= 1'b1;
      settle(8);
      check({7'h00, power_stage_hiz}, 8'h00);
      rd_all(8'h00, 8'h00, 8'h00);
      rd_chk(`OFS_PIN_MASK1, `RESET_PIN_MASK1);
      $display("reset in run test done");
      end_of_test();
   end
endmodule // amp_fault_warning_status_tb_top

`default_nettype wire
